// ### common/ext_irq_params.svh
// register offsets, field positions and reset values of the external pin interrupt unit
`ifndef EXT_IRQ_PARAMS_SVH
`define EXT_IRQ_PARAMS_SVH

// word-aligned byte offsets on the register bus
`define EXT_IRQ_OFS_ENABLE   8'h00
`define EXT_IRQ_OFS_PENDING  8'h04
`define EXT_IRQ_OFS_SENSE01  8'h08
`define EXT_IRQ_OFS_SENSE2   8'h0C

// enable and pending fields share positions
`define EXT_IRQ_BIT_ONE      7
`define EXT_IRQ_BIT_ZERO     6
`define EXT_IRQ_BIT_TWO      5

// sense control fields
`define EXT_IRQ_SENSE_ONE_LO  2
`define EXT_IRQ_SENSE_ZERO_LO 0
`define EXT_IRQ_SENSE_TWO_BIT 6

// reset values
`define EXT_IRQ_RST_ENABLE   3'h0
`define EXT_IRQ_RST_PENDING  3'h0
`define EXT_IRQ_RST_SENSE01  4'h0
`define EXT_IRQ_RST_SENSE2   1'h0

`endif

// ### common/ext_irq_pkg.sv
// types of the external pin interrupt unit
package ext_irq_pkg;

    // sense decode for pins zero and one, codes 00..11 in order
    typedef enum logic [1:0] {
        SENSE_LOW,
        SENSE_CHANGE,
        SENSE_FALL,
        SENSE_RISE
    } sense_mode_t;

endpackage

// ### rtl/external_pin_interrupt_unit.sv
// external pin interrupt unit: sense logic, pending flags, vector requests, wishbone registers
//
// Notes on behaviour
// R1: pin zero requests only while its enable bit and global enable are one.
// R2: two sense bits pick rising, falling, either edge or low level for pin zero.
// R3: pin level is sensed even when the pin is driven as an output.
// R4: each pin has its own vector request line.
// R5: pin two requests only while its enable bit and global enable are one.
// R6: pin two is edge sensed only; one bit picks rising or falling.
// R7: an edge or change on pin one sets pending flag one.
// R8: an edge or change on pin zero sets pending flag zero.
// R9: the selected edge on pin two sets pending flag two.
// R10: set flag plus enable plus global enable requests that pin's vector.
// R11: vector entry clears the matching pending flag.
// R12: writing one clears a pending flag; writing zero leaves it.
// R13: pending flags zero and one stay zero in low level mode.
// R14: sleep with pin two disabled cuts its buffer; the level change may set flag two.
// R15: sense pair 00 low, 01 any change, 10 falling, 11 rising.
// R16: pin two sense bit 0 is falling edge, 1 is rising edge.
// R17: pulses longer than one clock are caught; low levels must be held by the source.
// R18: software disables pin two and clears its flag around a sense change.
// R19: pins are synchronised and edges found by comparing successive samples.
// R20: reset clears enables, sense bits and pending flags.
// R21: in low level mode with enable, the request stands while the pin is low.
//
// Chosen here: the Wishbone register port and the register offsets.
`timescale 1ns/1ns
`include "ext_irq_params.svh"

module external_pin_interrupt_unit #(
    parameter int DATA_W = 32,
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // wishbone classic slave
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] adr_i,
    input  wire logic [DATA_W/8-1:0] sel_i,
    input  wire logic [DATA_W-1:0] dat_i,
    output logic      [DATA_W-1:0] dat_o,
    output logic                   ack_o,
    // external pins
    input  wire logic              ext_pin_zero_i,
    input  wire logic              ext_pin_one_i,
    input  wire logic              ext_pin_two_i,
    // processor core
    input  wire logic              global_irq_enable_i,
    input  wire logic              sleep_buffer_off_i,
    input  wire logic [2:0]        vector_taken_i,
    output logic      [2:0]        vector_req_o
);

    if (DATA_W != 32 || ADDR_W < 4) begin : g_check
        $error("external_pin_interrupt_unit needs DATA_W 32 and ADDR_W of 4 or more");
    end

    // pin index inside the three-bit vectors
    localparam int P0 = 0;
    localparam int P1 = 1;
    localparam int P2 = 2;

    // registered state
    logic [2:0] enable_reg;
    logic [2:0] pending_reg;
    logic [3:0] sense01_reg;
    logic       sense2_reg;
    logic [2:0] meta_reg;
    logic [2:0] sync_reg;
    logic [1:0] prev01_reg;
    logic       prev2_reg;
    logic       ack_reg;
    logic [DATA_W-1:0] rdata_reg;

    // combinational terms
    ext_irq_pkg::sense_mode_t mode0;
    ext_irq_pkg::sense_mode_t mode1;
    logic       pin2_level;
    logic       active2;
    logic [2:0] event_set;
    logic [2:0] sw_clear;
    logic [2:0] pending_next;
    logic [2:0] level_req;
    logic       bus_req;
    logic       wr_fire;
    logic       lane0;

    // one sense pair against the current and previous sample
    function automatic logic edge_event(input ext_irq_pkg::sense_mode_t m,
                                        input logic cur,
                                        input logic prev);
        unique case (m)
            ext_irq_pkg::SENSE_LOW:    edge_event = 1'b0;
            ext_irq_pkg::SENSE_CHANGE: edge_event = cur ^ prev;
            ext_irq_pkg::SENSE_FALL:   edge_event = prev & ~cur;
            ext_irq_pkg::SENSE_RISE:   edge_event = cur & ~prev;
        endcase
    endfunction

    // map the three pin bits to their byte positions
    function automatic logic [7:0] place_bits(input logic [2:0] v);
        place_bits = 8'h00;
        place_bits[`EXT_IRQ_BIT_ZERO] = v[P0];
        place_bits[`EXT_IRQ_BIT_ONE]  = v[P1];
        place_bits[`EXT_IRQ_BIT_TWO]  = v[P2];
    endfunction

    function automatic logic [2:0] pick_bits(input logic [7:0] b);
        pick_bits = {b[`EXT_IRQ_BIT_TWO], b[`EXT_IRQ_BIT_ONE], b[`EXT_IRQ_BIT_ZERO]};
    endfunction

    // pin synchronisers; the pad level is read whatever the pin direction [R3] [R19]
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= 3'h0;
            sync_reg <= 3'h0;
        end else begin
            meta_reg <= {ext_pin_two_i, ext_pin_one_i, ext_pin_zero_i};
            sync_reg <= meta_reg;
        end
    end

    // previous samples for edge compare [R19]
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev01_reg <= 2'h0;
            // folded pin two idles high with the pin low and falling sense, so no false edge after reset
            prev2_reg  <= 1'b1;
        end else begin
            prev01_reg <= sync_reg[P1:P0];
            prev2_reg  <= active2;
        end
    end

    assign mode0 = ext_irq_pkg::sense_mode_t'(sense01_reg[`EXT_IRQ_SENSE_ZERO_LO +: 2]); // [R2] [R15]
    assign mode1 = ext_irq_pkg::sense_mode_t'(sense01_reg[`EXT_IRQ_SENSE_ONE_LO +: 2]);  // [R15]

    // buffer cut in sleep when pin two is disabled reads as low [R14]
    assign pin2_level = sync_reg[P2] & ~(sleep_buffer_off_i & ~enable_reg[P2]);
    // pin two folded so that the chosen edge is always a rise; a sense change may fire [R6] [R16]
    assign active2 = sense2_reg ? pin2_level : ~pin2_level;

    assign event_set[P0] = edge_event(mode0, sync_reg[P0], prev01_reg[P0]); // [R8] [R17]
    assign event_set[P1] = edge_event(mode1, sync_reg[P1], prev01_reg[P1]); // [R7] [R17]
    assign event_set[P2] = active2 & ~prev2_reg;                            // [R9]

    // bus decode: one wait state, ack registered
    assign bus_req = cyc_i & stb_i;
    assign wr_fire = bus_req & we_i & ack_reg;
    assign lane0   = sel_i[0];

    assign sw_clear = (wr_fire && lane0 && adr_i[ADDR_W-1:2] == (ADDR_W-2)'(`EXT_IRQ_OFS_PENDING >> 2))
                    ? pick_bits(dat_i[7:0]) : 3'h0; // [R12]

    // set wins over vector entry and over software clear; low level holds zero [R11] [R12] [R13]
    always_comb begin
        pending_next = (pending_reg & ~sw_clear & ~vector_taken_i) | event_set;
        if (mode0 == ext_irq_pkg::SENSE_LOW) begin
            pending_next[P0] = 1'b0; // [R13]
        end
        if (mode1 == ext_irq_pkg::SENSE_LOW) begin
            pending_next[P1] = 1'b0; // [R13]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pending_reg <= `EXT_IRQ_RST_PENDING; // [R20]
        end else begin
            pending_reg <= pending_next;
        end
    end

    // control registers written at the acknowledged edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_reg  <= `EXT_IRQ_RST_ENABLE;  // [R20]
            sense01_reg <= `EXT_IRQ_RST_SENSE01; // [R20]
            sense2_reg  <= `EXT_IRQ_RST_SENSE2;  // [R20]
        end else if (wr_fire && lane0) begin
            unique case (adr_i[ADDR_W-1:2])
                (ADDR_W-2)'(`EXT_IRQ_OFS_ENABLE >> 2):  enable_reg  <= pick_bits(dat_i[7:0]);
                (ADDR_W-2)'(`EXT_IRQ_OFS_SENSE01 >> 2): sense01_reg <= dat_i[3:0];
                (ADDR_W-2)'(`EXT_IRQ_OFS_SENSE2 >> 2):  sense2_reg  <= dat_i[`EXT_IRQ_SENSE_TWO_BIT];
                default: ;
            endcase
        end
    end

    // ack and read data; unmapped addresses answer zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg   <= 1'b0;
            rdata_reg <= '0;
        end else begin
            ack_reg   <= bus_req & ~ack_reg;
            rdata_reg <= '0;
            if (bus_req && !ack_reg && !we_i) begin
                unique case (adr_i[ADDR_W-1:2])
                    (ADDR_W-2)'(`EXT_IRQ_OFS_ENABLE >> 2):  rdata_reg[7:0] <= place_bits(enable_reg);
                    (ADDR_W-2)'(`EXT_IRQ_OFS_PENDING >> 2): rdata_reg[7:0] <= place_bits(pending_reg);
                    (ADDR_W-2)'(`EXT_IRQ_OFS_SENSE01 >> 2): rdata_reg[3:0] <= sense01_reg;
                    (ADDR_W-2)'(`EXT_IRQ_OFS_SENSE2 >> 2):  rdata_reg[`EXT_IRQ_SENSE_TWO_BIT] <= sense2_reg;
                    default: ;
                endcase
            end
        end
    end

    assign ack_o = ack_reg;
    assign dat_o = rdata_reg;

    // level requests stand while the pin stays low [R21]
    assign level_req[P0] = (mode0 == ext_irq_pkg::SENSE_LOW) & ~sync_reg[P0];
    assign level_req[P1] = (mode1 == ext_irq_pkg::SENSE_LOW) & ~sync_reg[P1];
    assign level_req[P2] = 1'b0;

    // per-pin vector requests gated by pin enable and global enable [R1] [R4] [R5] [R10]
    assign vector_req_o = (pending_reg | level_req) & enable_reg & {3{global_irq_enable_i}};

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_zero_gate: assert property (vector_req_o[P0] |-> enable_reg[P0] && global_irq_enable_i) // [R1]
        else $error("pin zero request without both enables");

    a_two_gate: assert property (vector_req_o[P2] |-> enable_reg[P2] && global_irq_enable_i) // [R5]
        else $error("pin two request without both enables");

    a_vector_map: assert property ( // [R4]
        pending_reg[P2] && enable_reg[P2] && global_irq_enable_i |-> vector_req_o[P2])
        else $error("pin two flag did not reach its own vector");

    a_vector_one: assert property ( // [R10]
        pending_reg[P1] && enable_reg[P1] && global_irq_enable_i |-> vector_req_o[P1])
        else $error("pin one flag did not reach its vector");

    a_one_gate: assert property (vector_req_o[P1] |-> enable_reg[P1] && global_irq_enable_i) // [R10]
        else $error("pin one request without both enables");

    a_rise_zero: assert property ( // [R8]
        $rose(sync_reg[P0]) && mode0 == ext_irq_pkg::SENSE_RISE && !$past(rst_i) |=> pending_reg[P0])
        else $error("rising edge on pin zero did not set its flag");

    a_fall_one: assert property ( // [R7]
        $fell(sync_reg[P1]) && mode1 == ext_irq_pkg::SENSE_FALL && !$past(rst_i) |=> pending_reg[P1])
        else $error("falling edge on pin one did not set its flag");

    a_two_edge: assert property ( // [R9]
        !rst_i && sense2_reg && $stable(sense2_reg) && !sleep_buffer_off_i
        && $rose(sync_reg[P2]) |=> pending_reg[P2])
        else $error("selected edge on pin two did not set its flag");

    a_two_fall: assert property ( // [R16]
        !sense2_reg && $stable(sense2_reg) && !sleep_buffer_off_i && $stable(sleep_buffer_off_i)
        && $fell(sync_reg[P2]) |=> pending_reg[P2])
        else $error("falling edge on pin two did not set its flag");

    a_sleep_cut: assert property ( // [R14]
        $rose(sleep_buffer_off_i) && !enable_reg[P2] && $stable(enable_reg[P2]) && !sense2_reg
        && $stable(sense2_reg) && $past(sync_reg[P2]) |=> pending_reg[P2])
        else $error("buffer cut on pin two did not set its flag");

    a_level_clear: assert property ( // [R13]
        mode0 == ext_irq_pkg::SENSE_LOW ##1 mode0 == ext_irq_pkg::SENSE_LOW |-> !pending_reg[P0])
        else $error("pin zero flag set in low level mode");

    a_level_one: assert property ( // [R13]
        mode1 == ext_irq_pkg::SENSE_LOW ##1 mode1 == ext_irq_pkg::SENSE_LOW |-> !pending_reg[P1])
        else $error("pin one flag set in low level mode");

    a_level_hold: assert property ( // [R21]
        enable_reg[P1] && global_irq_enable_i && mode1 == ext_irq_pkg::SENSE_LOW && !sync_reg[P1]
        |-> vector_req_o[P1])
        else $error("low level on pin one gave no request");

    a_entry_clear: assert property (vector_taken_i[P0] && !event_set[P0] |=> !pending_reg[P0]) // [R11]
        else $error("vector entry did not clear flag zero");

    a_w1c_keep: assert property ( // [R12]
        wr_fire && lane0 && adr_i[ADDR_W-1:2] == (ADDR_W-2)'(`EXT_IRQ_OFS_PENDING >> 2)
        && !dat_i[`EXT_IRQ_BIT_TWO] && pending_reg[P2] && !vector_taken_i[P2] |=> pending_reg[P2])
        else $error("writing zero changed flag two");

    a_w1c_clear: assert property ( // [R12]
        wr_fire && lane0 && adr_i[ADDR_W-1:2] == (ADDR_W-2)'(`EXT_IRQ_OFS_PENDING >> 2)
        && dat_i[`EXT_IRQ_BIT_ZERO] && !event_set[P0] |=> !pending_reg[P0])
        else $error("writing one left flag zero set");

    a_edge_sample: assert property ( // [R19]
        event_set[P0] && mode0 == ext_irq_pkg::SENSE_CHANGE |-> sync_reg[P0] != prev01_reg[P0])
        else $error("change event without differing samples");

    a_pin_sync: assert property (sync_reg == $past(meta_reg)) // [R19]
        else $error("synchroniser stages out of step");

    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held for more than one cycle");

    a_ack_answer: assert property (bus_req && !ack_o |=> ack_o)
        else $error("bus request not acknowledged in the next cycle");

    a_read_idle: assert property (!ack_o |-> dat_o == '0)
        else $error("read data not zero outside the ack cycle");

endmodule

// ### bench/core_vector_model.sv
// processor core model: enters the lowest requested vector after a delay
`timescale 1ns/1ns

module core_vector_model (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // device side
    input  wire logic [2:0] vector_req_i,
    output logic      [2:0] vector_taken_o,
    // bench control
    input  wire logic       take_i,
    input  wire logic [3:0] delay_i
);
    logic [3:0] wait_reg;

    // one entry pulse, then a gap so the cleared request can drop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wait_reg       <= 4'h0;
            vector_taken_o <= 3'h0;
        end else begin
            vector_taken_o <= 3'h0;
            if (!take_i || vector_req_i == 3'h0 || vector_taken_o != 3'h0) begin
                wait_reg <= 4'h0;
            end else if (wait_reg != delay_i) begin
                wait_reg <= wait_reg + 4'h1;
            end else begin
                wait_reg       <= 4'h0;
                vector_taken_o <= vector_req_i & (~vector_req_i + 3'h1);
            end
        end
    end
endmodule

// ### bench/external_pin_interrupt_unit_test.sv
// self-checking bench for the external pin interrupt unit
`timescale 1ns/1ns
`include "ext_irq_params.svh"

module external_pin_interrupt_unit_test;
    localparam int CHG  = ext_irq_pkg::SENSE_CHANGE;
    localparam int FALL = ext_irq_pkg::SENSE_FALL;
    localparam int RISE = ext_irq_pkg::SENSE_RISE;
    logic        clk_i;
    logic        rst_i;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [31:0] got;
    logic        ack;
    logic [2:0]  pins;
    logic        global_en;
    logic        sleep_off;
    logic        take;
    logic [3:0]  take_delay;
    logic [2:0]  taken;
    logic [2:0]  vreq;
    int          errors;
    int          comparisons;
    logic [7:0]  ofs [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
    logic [31:0] after [5] = '{32'hE0, 32'h00, 32'h0F, 32'h40, 32'h00};

    external_pin_interrupt_unit u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .ext_pin_zero_i(pins[0]), .ext_pin_one_i(pins[1]), .ext_pin_two_i(pins[2]),
        .global_irq_enable_i(global_en), .sleep_buffer_off_i(sleep_off),
        .vector_taken_i(taken), .vector_req_o(vreq));

    core_vector_model u_core (
        .clk_i(clk_i), .rst_i(rst_i), .vector_req_i(vreq), .vector_taken_o(taken),
        .take_i(take), .delay_i(take_delay));

    initial begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic tally_and_finish();
        if (errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'h1 && n < 16);
        if (n >= 16) begin
            errors++;
            tally_and_finish();
        end
        got = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'h0, a, 32'h0);
        chk(got, exp);
    endtask

    task automatic clr();
        bus(1'h1, `EXT_IRQ_OFS_PENDING, 32'hE0);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    function automatic logic [31:0] flag(input int p);
        return p == 0 ? 32'h1 << `EXT_IRQ_BIT_ZERO : p == 1 ? 32'h1 << `EXT_IRQ_BIT_ONE : 32'h1 << `EXT_IRQ_BIT_TWO;
    endfunction

    initial begin
        errors = 0;
        comparisons = 0;
        rst_i <= 1'h1;
        {cyc, stb, we, adr, wdat} <= '0;
        {pins, global_en, sleep_off, take, take_delay} <= '0;
        tick(20);
        rst_i <= 1'h0;
        tick(1);
        for (int i = 0; i < 5; i++) begin
            rd(ofs[i], 32'h0);
            bus(1'h1, ofs[i], 32'hFF);
            rd(ofs[i], after[i]);
        end
        // every sense code on pins zero and one, both edges
        for (int p = 0; p < 2; p++) begin
            for (int m = 0; m < 4; m++) begin
                bus(1'h1, `EXT_IRQ_OFS_SENSE01, 32'(m) << (2 * p));
                tick(4);
                clr();
                pins[p] <= 1'h1;
                tick(5);
                rd(`EXT_IRQ_OFS_PENDING, (m == CHG || m == RISE) ? flag(p) : 32'h0);
                clr();
                pins[p] <= 1'h0;
                tick(5);
                rd(`EXT_IRQ_OFS_PENDING, (m == CHG || m == FALL) ? flag(p) : 32'h0);
            end
        end
        // pin two reacts to the selected edge only
        for (int m = 0; m < 2; m++) begin
            pins[2] <= (m == 0);
            bus(1'h1, `EXT_IRQ_OFS_SENSE2, 32'(m) << `EXT_IRQ_SENSE_TWO_BIT);
            tick(4);
            clr();
            pins[2] <= (m == 1);
            tick(5);
            rd(`EXT_IRQ_OFS_PENDING, flag(2));
            clr();
            pins[2] <= (m == 0);
            tick(5);
            rd(`EXT_IRQ_OFS_PENDING, 32'h0);
        end
        // requests gated by global enable, then served one by one
        pins <= 3'h0;
        bus(1'h1, `EXT_IRQ_OFS_SENSE01, 32'h0F);
        tick(4);
        clr();
        pins <= 3'h7;
        tick(5);
        chk(32'(vreq), 32'h0);
        global_en <= 1'h1;
        tick(2);
        chk(32'(vreq), 32'h7);
        take_delay <= 4'h3;
        take <= 1'h1;
        tick(24);
        chk(32'(vreq), 32'h0);
        rd(`EXT_IRQ_OFS_PENDING, 32'h0);
        take <= 1'h0;
        // low level request stands while the pin is low, no flag
        bus(1'h1, `EXT_IRQ_OFS_SENSE01, 32'h0);
        pins[1:0] <= 2'h0;
        tick(4);
        chk(32'(vreq), 32'h3);
        rd(`EXT_IRQ_OFS_PENDING, 32'h0);
        pins[1:0] <= 2'h3;
        tick(4);
        chk(32'(vreq), 32'h0);
        // sleep cut of pin two while disabled, then write-one clear
        bus(1'h1, `EXT_IRQ_OFS_ENABLE, 32'h0);
        bus(1'h1, `EXT_IRQ_OFS_SENSE2, 32'h0);
        tick(4);
        clr();
        sleep_off <= 1'h1;
        tick(5);
        rd(`EXT_IRQ_OFS_PENDING, flag(2));
        bus(1'h1, `EXT_IRQ_OFS_PENDING, 32'h0);
        rd(`EXT_IRQ_OFS_PENDING, flag(2));
        bus(1'h1, `EXT_IRQ_OFS_PENDING, flag(2));
        rd(`EXT_IRQ_OFS_PENDING, 32'h0);
        tally_and_finish();
    end
endmodule
